// [core/sas_sequencer.sv]
`timescale 1ns/1ps
`include "sas_defs.svh"
module sas_sequencer import sas_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Access requests
  input wire sas_req_s req,
  output logic reqReady,
  input wire logic [31:0] wrData,
  output logic wrDataTake,
  output logic [31:0] rdData,
  output logic rdValid,
  output logic accessDone,
  input wire logic closeAllBanks,
  // Memory side
  input wire logic external_bus_clock,
  input wire logic [31:0] memDataIn,
  output sas_pins_s pins
);
  sas_core_s q, d;
  logic extEdge;
  logic [2:0] idx;
  logic [17:0] rowKey;
  logic [7:0] hitVec;
  logic bankAct, bus16, holdBusy, curHit, rdLast;
  logic [1:0] lat, bank;
  logic [3:0] tpcCyc, trwlCyc;
  logic [2:0] lastBeat, colBits;
  logic [25:0] rowAddr, colAddr;

  assign extEdge = q.clkSync[1] & ~q.clkSync[2];
  assign bankAct = q.memCtl[`SAS_MC_BANKACT];
  assign bus16 = q.memCtl[`SAS_MC_BUS16];
  // Code 0 is taken as one cycle of latency for data capture; only code 1 inserts the no-op
  assign lat = q.req.area ? q.waitCtl[`SAS_WC_LAT3 +: 2] :
    q.waitCtl[`SAS_WC_LAT2 +: 2]; // [R08]
  assign tpcCyc = {2'h0, q.memCtl[`SAS_MC_TPC +: 2]} + 4'h1;
  assign trwlCyc = {2'h0, q.memCtl[`SAS_MC_TRWL +: 2]} + 4'h1;
  assign lastBeat = !q.req.burst ? 3'h0 : (bus16 ? 3'h7 : 3'h3); // [R12]
  assign holdBusy = req.area ? (q.hold3 != 4'h0) : (q.hold2 != 4'h0);

  // Bank select and row tag per address multiplex setting
  always_comb begin
    bank = q.memCtl[`SAS_MC_AMX] ? q.req.addr[24:23] : q.req.addr[23:22];
    idx = {q.req.area, bank};
    rowKey = q.req.addr[25:8];
    if (q.memCtl[`SAS_MC_AMX]) begin
      rowKey[0] = 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gHit
      assign hitVec[g] = q.openVld[g] && (q.openRow[g] == rowKey); // [R19]
    end
  endgenerate
  assign curHit = hitVec[idx];

  // Row and column address multiplexing
  always_comb begin
    rowAddr = q.req.addr;
    colAddr = q.req.addr;
    colBits = bus16 ? q.req.addr[3:1] + q.beat :
      {1'b0, q.req.addr[3:2] + q.beat[1:0]};
    if (q.memCtl[`SAS_MC_AMX]) begin
      rowAddr[15:0] = q.req.addr[24:9];
    end else begin
      rowAddr[13:0] = q.req.addr[21:8]; // [R03]
      rowAddr[15:14] = q.req.addr[23:22]; // [R03]
    end
    colAddr[15:14] = bank; // [R03]
    if (bus16) begin
      colAddr[3:1] = colBits; // [R10] [R11]
      colAddr[11] = 1'b0;
      colAddr[13:12] = q.req.addr[13:12];
    end else begin
      colAddr[3:2] = colBits[1:0]; // [R10] [R11]
      colAddr[12] = 1'b0;
    end
    rowAddr[25:16] = q.req.addr[25:16]; // [R23]
    colAddr[25:16] = q.req.addr[25:16]; // [R23]
  end

  assign reqReady = extEdge && q.st == SAS_IDLE && req.valid && !holdBusy;
  assign wrDataTake = extEdge && q.st == SAS_COL && q.req.write; // [R14]
  assign rdLast = q.beat == lastBeat;

  // Selects row strobe pair by half
  function automatic sas_pins_s strobe(input sas_pins_s p, input logic r,
    input logic c, input logic w, input logic up);
    sas_pins_s t;
    t = p;
    t.rowLowN = !(r && !up); // [R01]
    t.rowUpN = !(r && up); // [R01]
    t.colLowN = !(c && !up);
    t.colUpN = !(c && up);
    t.rdWrN = !w;
    return t;
  endfunction

  always_comb begin
    logic up;
    logic autoPre;
    up = q.memCtl[`SAS_MC_UPPER] && q.req.addr[`SAS_UPPER_BIT]; // [R01]
    autoPre = !bankAct && rdLast; // [R17]
    d = q;
    d.clkSync = {q.clkSync[1:0], external_bus_clock};
    d.dSync1 = memDataIn;
    d.dSync2 = q.dSync1;
    d.rdValid = 1'b0;
    d.done = 1'b0;
    d.regRd = 32'h0;
    if (regRd) begin
      case (regAddr)
        `SAS_OFS_MEMCTL: d.regRd = {19'h0, q.memCtl};
        `SAS_OFS_WAITCTL: d.regRd = {28'h0, q.waitCtl};
        `SAS_OFS_STATUS: d.regRd = {23'h0, q.openVld, q.st != SAS_IDLE};
        default: d.regRd = 32'h0;
      endcase
    end
    if (regWr && regAddr == `SAS_OFS_MEMCTL) begin
      d.memCtl = regWdata[12:0];
    end
    if (regWr && regAddr == `SAS_OFS_WAITCTL) begin
      d.waitCtl = regWdata[3:0];
    end
    if (extEdge) begin
      d.pins = strobe(q.pins, 1'b0, 1'b0, 1'b0, up);
      d.pins.dataOe = 1'b0;
      d.pins.busStartN = 1'b1;
      d.pipe = {q.pipe[2:0], 1'b0};
      if (q.hold2 != 4'h0) begin
        d.hold2 = q.hold2 - 4'h1;
      end
      if (q.hold3 != 4'h0) begin
        d.hold3 = q.hold3 - 4'h1;
      end
      // Memory samples the command one edge late, so count from there
      if (q.pipe[lat == 2'h0 ? 2'h1 : lat]) begin
        d.rdData = q.dSync2; // [R04] [R08]
        d.rdValid = 1'b1;
      end
      if (d.pipe[lat == 2'h0 ? 2'h1 : lat]) begin
        d.pins.busStartN = 1'b0; // [R09]
      end
      case (q.st)
        SAS_IDLE: begin
          if (reqReady) begin
            d.req = req;
            d.beat = 3'h0;
            d.st = SAS_ACT;
          end
        end
        SAS_PRE: begin
          d.pins = strobe(d.pins, 1'b1, 1'b0, 1'b1, up); // [R20]
          d.pins.addr = rowAddr;
          d.pins.addr[12] = 1'b0;
          d.openVld[idx] = 1'b0;
          d.waitCnt = tpcCyc; // [R21]
          d.st = SAS_PREW;
        end
        SAS_PREW: begin
          d.waitCnt = q.waitCnt - 4'h1;
          if (q.waitCnt == 4'h1) begin
            d.st = SAS_ACT; // [R20]
          end
        end
        SAS_ACT: begin
          d.pins = strobe(d.pins, 1'b1, 1'b0, 1'b0, up); // [R04] [R16]
          d.pins.addr = rowAddr;
          if (bankAct) begin
            d.openVld[idx] = 1'b1; // [R19]
            d.openRow[idx] = rowKey;
          end
          d.waitCnt = {2'h0, q.memCtl[`SAS_MC_RCD +: 2]}; // [R06]
          if (q.memCtl[`SAS_MC_RCD +: 2] != 2'h0) begin
            d.st = SAS_RCDW; // [R07]
          end else if (!q.req.write && lat == 2'h1) begin
            d.st = SAS_NOPC; // [R25]
          end else begin
            d.st = SAS_COL;
          end
        end
        SAS_RCDW: begin
          d.waitCnt = q.waitCnt - 4'h1; // [R07]
          if (q.waitCnt == 4'h1) begin
            d.st = (!q.req.write && lat == 2'h1) ? SAS_NOPC : SAS_COL;
          end
        end
        SAS_NOPC: begin
          d.st = SAS_COL; // [R25]
        end
        SAS_COL: begin
          d.pins = strobe(d.pins, 1'b0, 1'b1, q.req.write, up);
          d.pins.addr = colAddr;
          d.pins.addr[bus16 ? 11 : 12] = autoPre; // [R02] [R17]
          d.beat = q.beat + 3'h1;
          if (q.req.write) begin
            d.pins.dataOut = wrData; // [R14] [R16]
            d.pins.dataOe = 1'b1;
            d.pins.busStartN = 1'b0; // [R09]
          end else begin
            d.pipe[0] = 1'b1; // [R04]
          end
          if (rdLast) begin
            // Burst only arrives for line fill, line write-back or 16-byte DMA
            if (autoPre) begin
              if (q.req.area) begin
                d.hold3 = tpcCyc + (q.req.write ? trwlCyc : 4'h0); // [R05] [R15]
              end else begin
                d.hold2 = tpcCyc + (q.req.write ? trwlCyc : 4'h0); // [R05] [R15]
              end
            end
            d.st = q.req.write ? SAS_IDLE : SAS_LAT; // [R13]
            d.done = q.req.write;
          end
        end
        SAS_LAT: begin
          if (d.pipe == 4'h0) begin
            d.st = SAS_IDLE;
            d.done = 1'b1;
          end
        end
        default: d.st = SAS_IDLE;
      endcase
      if (q.st == SAS_IDLE && reqReady && bankAct) begin
        d.req = req;
        d.st = SAS_ACT;
      end
    end
    // Decision on the freshly latched request, one edge later
    if (extEdge && q.st == SAS_ACT && bankAct && q.openVld[idx]) begin
      if (curHit) begin
        d.pins = strobe(q.pins, 1'b0, 1'b0, 1'b0, up); // [R18]
        d.pins.dataOe = 1'b0;
        d.pins.busStartN = q.pins.busStartN;
        d.st = (!q.req.write && lat == 2'h1) ? SAS_NOPC : SAS_COL; // [R18]
        d.openVld = q.openVld;
      end else begin
        d.pins = strobe(q.pins, 1'b0, 1'b0, 1'b0, up);
        d.pins.dataOe = 1'b0;
        d.pins.busStartN = 1'b1;
        d.st = SAS_PRE; // [R20]
        d.openVld = q.openVld;
      end
    end
    if (closeAllBanks) begin
      d.openVld = 8'h0; // [R24]
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= SAS_IDLE;
      q.memCtl <= `SAS_MC_RESET;
      q.waitCtl <= `SAS_WC_RESET;
      q.pins.rowLowN <= 1'b1;
      q.pins.rowUpN <= 1'b1;
      q.pins.colLowN <= 1'b1;
      q.pins.colUpN <= 1'b1;
      q.pins.rdWrN <= 1'b1;
      q.pins.busStartN <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign regRdata = q.regRd;
  assign rdData = q.rdData;
  assign rdValid = q.rdValid;
  assign accessDone = q.done;
  assign pins = q.pins;
  // Open rows are only bounded by software refresh or bank close
endmodule // sas_sequencer

// [include/sas_defs.svh]
// Overview of operation
// R01: Upper strobes serve upper 32-Mbyte half
// R02: Column-cycle A10 pin carries precharge flag
// R03: Setting 0100: A23/A22 bank, row A8-A21
// R04: Burst read: activate, three reads, read-precharge
// R05: Precharge wait blocks same memory only
// R06: Activate delay codes 0-3 give 1-4
// R07: Extra activate delay cycles are no-ops
// R08: Read latency 1-3 per area
// R09: Bus-start strobe in every data cycle
// R10: Burst steps low column bits only
// R11: Line fill wraps from missed word
// R12: Single read fetches one datum only
// R13: Burst writes only for line transfers
// R14: Burst write: activate, writes, write-precharge
// R15: Write recovery then precharge wait
// R16: Single write: activate, write-precharge with data
// R17: Bank-active mode drops auto-precharge
// R18: Open-row hit skips activate
// R19: One open row per bank
// R20: Row miss: precharge, wait, activate, access
// R21: Precharge-to-activate gap from wait field
// R22: Software refreshes before row-active limit
// R23: High address bits never multiplexed
// R24: Refresh or bus release closes banks
// R25: Latency one inserts no-op before read
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH
`define SAS_OFS_MEMCTL 4'h0
`define SAS_OFS_WAITCTL 4'h4
`define SAS_OFS_STATUS 4'h8
`define SAS_MC_AMX 0
`define SAS_MC_RCD 4
`define SAS_MC_TPC 6
`define SAS_MC_TRWL 8
`define SAS_MC_BANKACT 10
`define SAS_MC_UPPER 11
`define SAS_MC_BUS16 12
`define SAS_WC_LAT2 0
`define SAS_WC_LAT3 2
`define SAS_MC_RESET 13'h0004
`define SAS_WC_RESET 4'h5
`define SAS_UPPER_BIT 25
`endif

// [include/sas_pkg.sv]
package sas_pkg;
  typedef enum logic [2:0] {
    SAS_IDLE, SAS_PRE, SAS_PREW, SAS_ACT, SAS_RCDW, SAS_NOPC, SAS_COL,
    SAS_LAT
  } sas_state_e;

  // Memory pins, strobes active low
  typedef struct packed {
    logic rowLowN;
    logic rowUpN;
    logic colLowN;
    logic colUpN;
    logic rdWrN;
    logic busStartN;
    logic dataOe;
    logic [25:0] addr;
    logic [31:0] dataOut;
  } sas_pins_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic burst;
    logic area;
    logic [25:0] addr;
  } sas_req_s;

  typedef struct packed {
    sas_state_e st;
    sas_req_s req;
    logic [2:0] beat;
    logic [3:0] waitCnt;
    logic [3:0] pipe;
    logic [3:0] hold2;
    logic [3:0] hold3;
    logic [7:0] openVld;
    logic [7:0][17:0] openRow;
    logic [12:0] memCtl;
    logic [3:0] waitCtl;
    logic [31:0] rdData;
    logic rdValid;
    logic done;
    logic [31:0] regRd;
    sas_pins_s pins;
    logic [2:0] clkSync;
    logic [31:0] dSync1;
    logic [31:0] dSync2;
  } sas_core_s;
endpackage

// [testbench/sas_sequencer_chk.sv]
`timescale 1ns/1ps
module sas_sequencer_chk import sas_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Requests and data
  input wire sas_req_s req,
  input wire logic reqReady,
  input wire logic [31:0] wrData,
  input wire logic wrDataTake,
  input wire logic rdValid,
  input wire logic accessDone,
  // Memory side
  input wire sas_pins_s pins
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Pins hold a whole bus clock, at least 8 fast cycles
  sequence colHeld;
    !pins.colLowN [*8];
  endsequence
  sequence rowHeld;
    !pins.rowLowN [*8];
  endsequence
  sequence wrBeat;
    pins.dataOe && !pins.rdWrN && !pins.busStartN;
  endsequence
  chk_one_row_strobe: assert property (!(!pins.rowLowN && !pins.rowUpN))
    else $error("both row strobes low");
  chk_write_beat: assert property (wrDataTake |=>
    (wrBeat and pins.dataOut == $past(wrData)))
    else $error("write beat not driven");
  chk_col_hold: assert property ($fell(pins.colLowN) |-> colHeld)
    else $error("column strobe too short");
  chk_row_hold: assert property ($fell(pins.rowLowN) |-> rowHeld)
    else $error("row strobe too short");
  chk_ready_valid: assert property (reqReady |-> req.valid)
    else $error("request taken without valid");
  chk_read_pulse: assert property (rdValid |=> !rdValid)
    else $error("read beat longer than one cycle");
  chk_done_bound: assert property (reqReady |-> ##[20:1000] accessDone)
    else $error("access did not finish");
  chk_done_pulse: assert property (accessDone |=> !accessDone)
    else $error("done longer than one cycle");
endmodule // sas_sequencer_chk

bind sas_sequencer sas_sequencer_chk u_chk (.mclk, .sys_rst, .req, .reqReady,
  .wrData, .wrDataTake, .rdValid, .accessDone, .pins);

// [testbench/sas_mem_model.sv]
`timescale 1ns/1ps
module sas_mem_model import sas_pkg::*; (
  // Memory bus
  input wire logic external_bus_clock,
  input wire sas_pins_s pins,
  output logic [31:0] memDataIn
);
  logic [31:0] mem [1024];
  logic [1:0] vld;
  logic [31:0] d0, d1;
  logic [9:0] idx;
  logic colCmd;
  // Row bits ignored: one page per bank is enough here
  assign idx = {pins.addr[15:14], pins.addr[9:2]};
  assign colCmd = pins.rowLowN && pins.rowUpN && !(pins.colLowN && pins.colUpN);
  initial begin
    vld = 2'h0;
    memDataIn = 32'h0;
  end
  always @(posedge external_bus_clock) begin : beat
    logic rd;
    logic [31:0] d;
    rd = colCmd && pins.rdWrN;
    d = mem[idx];
    if (colCmd && !pins.rdWrN) begin
      mem[idx] = pins.dataOut;
    end
    // Data held past the edge; released bus toggles
    #80;
    vld = {vld[0], rd};
    d1 = d0;
    d0 = d;
    memDataIn = vld[1] ? d1 : ~memDataIn;
  end
endmodule // sas_mem_model

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import sas_pkg::*;
  typedef struct packed {
    logic wr;
    logic bst;
    logic [25:0] addr;
    logic [31:0] dat;
  } sas_row_s;
  logic mclk, sys_rst, regWr, regRd, closeAllBanks, extClk;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata, wrData, rdData, memDataIn;
  logic reqReady, wrDataTake, rdValid, accessDone;
  sas_req_s req;
  sas_pins_s pins;
  int error_cnt, checks, rowFalls, upFalls;
  logic [31:0] rdq [$];
  sas_row_s rows [4] = '{'{1'b1, 1'b0, 26'h40, 32'h11110000},
    '{1'b0, 1'b0, 26'h40, 32'h11110000}, '{1'b1, 1'b1, 26'h100, 32'h22220000},
    '{1'b0, 1'b1, 26'h104, 32'h22220001}};
  sas_sequencer dut (.mclk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .req, .reqReady, .wrData, .wrDataTake, .rdData, .rdValid,
    .accessDone, .closeAllBanks, .external_bus_clock(extClk), .memDataIn,
    .pins);
  sas_mem_model mem (.external_bus_clock(extClk), .pins, .memDataIn);
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    extClk = 0;
    #3;
    forever #80 extClk = ~extClk;
  end
  always @(posedge mclk) begin
    if (rdValid) rdq.push_back(rdData);
    if (wrDataTake) wrData <= {wrData[31:2], wrData[1:0] + 2'h1};
  end
  always @(negedge pins.rowLowN) rowFalls++;
  always @(negedge pins.rowUpN) upFalls++;
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rdReg(input logic [3:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    cmp("regRdata", e, regRdata);
    @(posedge mclk);
  endtask
  task automatic access(input sas_row_s r, input int nRow, input int nUp);
    int n;
    rdq = {};
    rowFalls = 0;
    upFalls = 0;
    wrData <= r.dat;
    req <= '{1'b1, r.wr, r.bst, 1'b0, r.addr};
    n = 0;
    do begin @(posedge mclk); n++; end while (reqReady !== 1'b1 && n < 2000);
    req.valid <= 1'b0;
    do begin @(posedge mclk); n++; end while (accessDone !== 1'b1 && n < 4000);
    @(posedge mclk);
    cmp("finished", 32'h1, 32'(n < 4000));
    if (!r.wr) begin
      cmp("beats", r.bst ? 32'h4 : 32'h1, rdq.size());
      foreach (rdq[i]) cmp("rdData", {r.dat[31:2], r.dat[1:0] + 2'(i)}, rdq[i]);
    end
    cmp("rowFalls", nRow, rowFalls);
    cmp("upFalls", nUp, upFalls);
  endtask
  task automatic closeBanks;
    closeAllBanks <= 1'b1;
    @(posedge mclk);
    closeAllBanks <= 1'b0;
  endtask
  initial begin
    {regWr, regRd, closeAllBanks, regAddr, regWdata, wrData} = '0;
    req = '0;
    sys_rst = 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rdReg(4'h0, 32'h00000004);
    rdReg(4'h4, 32'h00000005);
    rdReg(4'hC, 32'h0);
    wrReg(4'h4, 32'h0000000A);
    rdReg(4'h4, 32'h0000000A);
    foreach (rows[i]) access(rows[i], 1, 0);
    // Bank-active: open, hit, miss, then closed by refresh
    wrReg(4'h0, 32'h00000404);
    access(rows[1], 1, 0);
    access(rows[1], 0, 0);
    access('{1'b1, 1'b0, 26'h10080, 32'h33330000}, 2, 0);
    closeBanks();
    access(rows[1], 1, 0);
    closeBanks();
    wrReg(4'h0, 32'h00000804);
    access('{1'b0, 1'b0, 26'h2000040, 32'h11110000}, 0, 1);
    stop_test();
  end
  initial begin
    #300000;
    error_cnt++;
    stop_test();
  end
endmodule // testbench
